// [hdl/ardc_axis_drive.sv]
// One axis of relative drive: pulse steering, busy and position count.
// Assumes start is a one-cycle pulse and the in-position level is synchronised.
`timescale 1ns/1ps
module ardc_axis_drive (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Start request and its signed pulse count.
  input wire logic start,
  input wire logic signed [31:0] pulse_count,
  // Servo in-position handling.
  input wire logic inpos_enable,
  input wire logic inpos_active,
  // Axis outputs.
  output logic busy,
  output logic plus_pulse_output,
  output logic minus_pulse_output,
  output logic signed [31:0] logical_position
);
  import ardc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ardc_drv_e state_reg; // Sequencer state.
  logic [31:0] remain_reg; // Pulses still to emit.
  logic [7:0] period_reg; // Position inside one pulse period.
  logic dir_pos_reg; // High when pulses go to the plus output.
  logic emit; // A pulse leaves on the next edge.

  assign emit = (state_reg == DRV_RUN) && (remain_reg != 32'h00000000) && (period_reg == 8'h00);
  assign busy = (state_reg != DRV_IDLE);

  // Sequencer: run until the count is spent, then optionally hold.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= DRV_IDLE;
    end else begin
      unique case (state_reg)
        DRV_IDLE: begin
          if (start) begin
            state_reg <= DRV_RUN;
          end
        end
        DRV_RUN: begin
          if (remain_reg == 32'h00000000) begin
            // The servo may still be settling, so busy is kept until it reports.
            state_reg <= (inpos_enable && !inpos_active) ? DRV_HOLD : DRV_IDLE;
          end
        end
        DRV_HOLD: begin
          if (inpos_active) begin
            state_reg <= DRV_IDLE;
          end
        end
        default: begin
          state_reg <= DRV_IDLE;
        end
      endcase
    end
  end

  // Count and direction are latched at start; the sign picks the output.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      remain_reg <= 32'h00000000;
      dir_pos_reg <= 1'b1;
    end else if (start && state_reg == DRV_IDLE) begin
      dir_pos_reg <= !pulse_count[31];
      remain_reg <= pulse_count[31] ? 32'(-pulse_count) : 32'(pulse_count);
    end else if (emit) begin
      remain_reg <= remain_reg - 32'h00000001;
    end
  end

  // Period counter paces the pulses; no profile generator is modelled.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      period_reg <= 8'h00;
    end else if (state_reg != DRV_RUN || period_reg == 8'(PULSE_PERIOD_CYC - 1)) begin
      period_reg <= 8'h00;
    end else begin
      period_reg <= period_reg + 8'h01;
    end
  end

  // Registered pulse outputs, one cycle high per pulse.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      plus_pulse_output <= 1'b0;
      minus_pulse_output <= 1'b0;
    end else begin
      plus_pulse_output <= emit && dir_pos_reg;
      minus_pulse_output <= emit && !dir_pos_reg;
    end
  end

  // Logical position follows every emitted pulse.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      logical_position <= 32'sh00000000;
    end else if (emit) begin
      logical_position <= dir_pos_reg ? logical_position + 32'sh00000001
                                      : logical_position - 32'sh00000001;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_plus_counts_up: assert property (@(posedge ref_clk) disable iff (rst)
    plus_pulse_output |-> logical_position == $past(logical_position) + 32'sh00000001)
    else $error("position did not rise with a plus pulse");
  a_minus_counts_down: assert property (@(posedge ref_clk) disable iff (rst)
    minus_pulse_output |-> logical_position == $past(logical_position) - 32'sh00000001)
    else $error("position did not fall with a minus pulse");
  a_pulse_steering: assert property (@(posedge ref_clk) disable iff (rst)
    (start && !busy && pulse_count > 32'sh00000000) |=> dir_pos_reg && !minus_pulse_output)
    else $error("positive count not steered to plus output");
  a_hold_keeps_busy: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == DRV_HOLD && !inpos_active) |=> busy)
    else $error("busy dropped before in-position");
  a_busy_while_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    (plus_pulse_output || minus_pulse_output) |-> busy)
    else $error("pulse emitted while not busy");
  c_hold_entered: cover property (@(posedge ref_clk) disable iff (rst) state_reg == DRV_HOLD);
  c_minus_drive: cover property (@(posedge ref_clk) disable iff (rst) minus_pulse_output);

endmodule : ardc_axis_drive

// [hdl/ardc_cmd_top.sv]
// Command interpreter for the pulse-count, split and input readbacks and relative drive.
// Assumes the host writes a command word as a one-cycle strobe synchronous to ref_clk;
// pins from outside the clock domain are synchronised here.
`timescale 1ns/1ps

// Behaviour
// - Pulse count readback fills both read registers.
// - Readback returns value loaded by synchronous action.
// - Pulse count limited to plus/minus 2^31-2.
// - Split readback: length low, width high.
// - Split length 2..65535, width 1..65534.
// - Split readback reports synchronously loaded value.
// - Input readback needs no axis selection.
// - Low register holds bus pins in I2C mode.
// - General inputs in high register bits 7..0.
// - Low pin reads 0, high pin reads 1.
// - Drive command starts selected axes at once.
// - Busy bit high while axis emits pulses.
// - Busy held until servo in-position when enabled.
// - Positive count plus output, negative minus output.
// - Position counts up plus, down minus.
module ardc_cmd_top (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Command register write: code in bits 7..0, axes in bits 11..8.
  input wire logic command_wr,
  input wire logic [15:0] command_register,
  input wire logic [31:0] command_param,
  // Synchronous action loads from the multi-purpose register.
  input wire logic [ardc_pkg::AXES-1:0] sync_load_pulse_count,
  input wire logic [ardc_pkg::AXES-1:0] sync_load_split,
  input wire logic [31:0] multi_purpose_reg,
  // Pins sampled by the input readback.
  input wire logic i2c_mode_pin,
  input wire logic [15:0] host_data_bus_pins,
  input wire logic [7:0] general_input_pins,
  // Servo in-position pins and their enables.
  input wire logic [ardc_pkg::AXES-1:0] servo_in_position_input,
  input wire logic [ardc_pkg::AXES-1:0] inpos_enable,
  // Read data and status.
  output logic [ardc_pkg::WORD_W-1:0] read_data_low,
  output logic [ardc_pkg::WORD_W-1:0] read_data_high,
  output logic [ardc_pkg::WORD_W-1:0] main_status_register,
  // Axis pulse outputs and position counters.
  output logic [ardc_pkg::AXES-1:0] plus_pulse_output,
  output logic [ardc_pkg::AXES-1:0] minus_pulse_output,
  output logic [ardc_pkg::AXES*32-1:0] logical_position
);
  import ardc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] cmd_code; // Decoded command code.
  logic [AXES-1:0] cmd_axes; // Decoded axis selection.
  logic [1:0] rd_axis; // Lowest selected axis, used by readbacks.
  logic signed [31:0] pulse_count_finish_point_reg [AXES]; // Per-axis pulse count.
  logic [15:0] split_len_reg [AXES]; // Per-axis split length.
  logic [15:0] split_width_reg [AXES]; // Per-axis split pulse width.
  logic [AXES-1:0] axis_busy_bit; // Busy flags from the axes.
  logic [AXES-1:0] drive_start; // One-cycle start per axis.
  logic [AXES-1:0] inpos_sync; // Synchronised in-position levels.
  logic [15:0] bus_sync; // Synchronised host data bus pins.
  logic [7:0] gpin_sync; // Synchronised general input pins.
  logic i2c_sync; // Synchronised interface mode strap.
  logic signed [31:0] param_clamped; // Written pulse count held within range.
  logic signed [31:0] mpr_clamped; // Loaded pulse count held within range.

  assign cmd_code = command_register[CMD_CODE_MSB:CMD_CODE_LSB];
  assign cmd_axes = command_register[CMD_AXIS_MSB:CMD_AXIS_LSB];
  assign main_status_register = {{(WORD_W - AXES){1'b0}}, axis_busy_bit};

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ardc_sync2 #(.W(16)) u_sync_bus (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(host_data_bus_pins),
    .sync_out(bus_sync)
  );

  ardc_sync2 #(.W(8)) u_sync_gpin (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(general_input_pins),
    .sync_out(gpin_sync)
  );

  ardc_sync2 #(.W(AXES + 1)) u_sync_misc (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({i2c_mode_pin, servo_in_position_input}),
    .sync_out({i2c_sync, inpos_sync})
  );

  // ----------------------------------------------------------------
  // Axis selection and range limiting
  // ----------------------------------------------------------------

  // Readbacks report one axis; the lowest selected one wins a multi-axis write.
  always_comb begin
    rd_axis = 2'd0;
    for (int i = AXES - 1; i >= 0; i--) begin
      if (cmd_axes[i]) begin
        rd_axis = 2'(i);
      end
    end
  end

  // Clamping protects the drive from counts whose magnitude cannot be negated.
  function automatic logic signed [31:0] clamp_count(input logic signed [31:0] v);
    if (v > PULSE_COUNT_MAX) begin
      return PULSE_COUNT_MAX;
    end else if (v < PULSE_COUNT_MIN) begin
      return PULSE_COUNT_MIN;
    end
    return v;
  endfunction : clamp_count

  // Split length below its floor is raised to it.
  function automatic logic [15:0] clamp_len(input logic [15:0] v);
    return (v < SPLIT_LEN_MIN) ? SPLIT_LEN_MIN : v;
  endfunction : clamp_len

  // Split width is held inside 1..65534.
  function automatic logic [15:0] clamp_width(input logic [15:0] v);
    if (v < SPLIT_WIDTH_MIN) begin
      return SPLIT_WIDTH_MIN;
    end else if (v > SPLIT_WIDTH_MAX) begin
      return SPLIT_WIDTH_MAX;
    end
    return v;
  endfunction : clamp_width

  assign param_clamped = clamp_count(command_param);
  assign mpr_clamped = clamp_count(multi_purpose_reg);

  // ----------------------------------------------------------------
  // Parameter storage
  // ----------------------------------------------------------------

  // Pulse count: a synchronous load takes precedence over a host write in the
  // same cycle, since the action is the later event in the machine's view.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < AXES; i++) begin
        pulse_count_finish_point_reg[i] <= PULSE_COUNT_RST;
      end
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (sync_load_pulse_count[i]) begin
          pulse_count_finish_point_reg[i] <= mpr_clamped;
        end else if (command_wr && cmd_code == CMD_SET_PULSE_COUNT && cmd_axes[i]) begin
          pulse_count_finish_point_reg[i] <= param_clamped;
        end
      end
    end
  end

  // Split settings: length in the low half of the value, width in the high half.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < AXES; i++) begin
        split_len_reg[i] <= SPLIT_LEN_RST;
        split_width_reg[i] <= SPLIT_WIDTH_RST;
      end
    end else begin
      for (int i = 0; i < AXES; i++) begin
        if (sync_load_split[i]) begin
          split_len_reg[i] <= clamp_len(multi_purpose_reg[15:0]);
          split_width_reg[i] <= clamp_width(multi_purpose_reg[31:16]);
        end else if (command_wr && cmd_code == CMD_SET_SPLIT && cmd_axes[i]) begin
          split_len_reg[i] <= clamp_len(command_param[15:0]);
          split_width_reg[i] <= clamp_width(command_param[31:16]);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Readback registers
  // ----------------------------------------------------------------

  // Other codes leave the read registers unchanged so a late read still sees
  // the previous answer.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      read_data_low <= READ_DATA_RST;
      read_data_high <= READ_DATA_RST;
    end else if (command_wr) begin
      unique case (cmd_code)
        CMD_READ_PULSE_COUNT: begin
          read_data_low <= pulse_count_finish_point_reg[rd_axis][15:0];
          read_data_high <= pulse_count_finish_point_reg[rd_axis][31:16];
        end
        CMD_READ_SPLIT: begin
          read_data_low <= split_len_reg[rd_axis];
          read_data_high <= split_width_reg[rd_axis];
        end
        CMD_READ_INPUTS: begin
          // Axis bits are ignored entirely here.
          read_data_low <= i2c_sync ? bus_sync : 16'h0000;
          read_data_high <= {8'h00, gpin_sync};
        end
        default: begin
          read_data_low <= read_data_low;
          read_data_high <= read_data_high;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Axes
  // ----------------------------------------------------------------

  // A relative drive starts every selected axis in the write cycle itself;
  // a busy axis ignores the request inside its sequencer.
  assign drive_start = (command_wr && cmd_code == CMD_DRIVE_RELATIVE) ? cmd_axes
                                                                       : '0;

  for (genvar g = 0; g < AXES; g++) begin : g_axis
    ardc_axis_drive u_axis (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(drive_start[g]),
      .pulse_count(pulse_count_finish_point_reg[g]),
      .inpos_enable(inpos_enable[g]),
      .inpos_active(inpos_sync[g]),
      .busy(axis_busy_bit[g]),
      .plus_pulse_output(plus_pulse_output[g]),
      .minus_pulse_output(minus_pulse_output[g]),
      .logical_position(logical_position[g*32 +: 32])
    );
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_tp_readback: assert property (
    (command_wr && cmd_code == CMD_READ_PULSE_COUNT) |=>
      {read_data_high, read_data_low} == $past(pulse_count_finish_point_reg[rd_axis]))
    else $error("pulse count readback mismatch");
  a_tp_sync_load: assert property (
    sync_load_pulse_count[0] |=> pulse_count_finish_point_reg[0] == $past(mpr_clamped))
    else $error("synchronous load not taken");
  a_tp_in_range: assert property (
    pulse_count_finish_point_reg[0] <= PULSE_COUNT_MAX
      && pulse_count_finish_point_reg[0] >= PULSE_COUNT_MIN)
    else $error("pulse count out of range");
  a_split_readback: assert property (
    (command_wr && cmd_code == CMD_READ_SPLIT) |=>
      read_data_low == $past(split_len_reg[rd_axis])
      && read_data_high == $past(split_width_reg[rd_axis]))
    else $error("split readback mismatch");
  a_split_range: assert property (
    split_len_reg[0] >= SPLIT_LEN_MIN && split_width_reg[0] >= SPLIT_WIDTH_MIN
      && split_width_reg[0] <= SPLIT_WIDTH_MAX)
    else $error("split setting out of range");
  a_input_readback: assert property (
    (command_wr && cmd_code == CMD_READ_INPUTS) |=>
      read_data_low == ($past(i2c_sync) ? $past(bus_sync) : 16'h0000))
    else $error("bus pin readback wrong");
  a_gpin_upper_zero: assert property (
    (command_wr && cmd_code == CMD_READ_INPUTS) |=>
      read_data_high == {8'h00, $past(gpin_sync)})
    else $error("general input readback wrong");
  a_drive_busy: assert property (
    (drive_start[0] && pulse_count_finish_point_reg[0] != 32'sh00000000) |=>
      main_status_register[0] ##1 main_status_register[0])
    else $error("drive did not raise busy");

  c_readback_tp: cover property (command_wr && cmd_code == CMD_READ_PULSE_COUNT);
  c_i2c_inputs: cover property (command_wr && cmd_code == CMD_READ_INPUTS && i2c_sync);
  c_drive_done: cover property (main_status_register[0] ##1 !main_status_register[0]);

endmodule : ardc_cmd_top

// [hdl/ardc_sync2.sv]
// Two-flop synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/1ps
module ardc_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Asynchronous level in, synchronised level out.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  logic [W-1:0] meta_reg; // First stage, read only by the second stage.

  // Both stages reset to zero so reads after reset are defined.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : ardc_sync2

// [include/ardc_pkg.sv]
// Package for the per-axis readback and drive command block.
// Assumes a single 100 MHz reference clock shared by every file of the block.
package ardc_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int AXES = 4;                 // Number of axes served.
  localparam int WORD_W = 16;              // Width of each read data register.

  // ----------------------------------------------------------------
  // Command register layout
  // ----------------------------------------------------------------
  localparam int CMD_CODE_LSB = 0;         // Command code field, bits 7..0.
  localparam int CMD_CODE_MSB = 7;
  localparam int CMD_AXIS_LSB = 8;         // Axis selection field, bits 11..8.
  localparam int CMD_AXIS_MSB = 11;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SET_PULSE_COUNT = 8'h06;
  localparam logic [7:0] CMD_SET_SPLIT = 8'h17;
  localparam logic [7:0] CMD_READ_PULSE_COUNT = 8'h46;
  localparam logic [7:0] CMD_READ_SPLIT = 8'h47;
  localparam logic [7:0] CMD_READ_INPUTS = 8'h48;
  localparam logic [7:0] CMD_DRIVE_RELATIVE = 8'h50;

  // ----------------------------------------------------------------
  // Parameter limits and reset values
  // ----------------------------------------------------------------
  localparam logic signed [31:0] PULSE_COUNT_MAX = 32'sh7FFFFFFE;
  localparam logic signed [31:0] PULSE_COUNT_MIN = -32'sh7FFFFFFE;
  localparam logic signed [31:0] PULSE_COUNT_RST = 32'sh00000000;
  localparam logic [15:0] SPLIT_LEN_MIN = 16'h0002;
  localparam logic [15:0] SPLIT_WIDTH_MIN = 16'h0001;
  localparam logic [15:0] SPLIT_WIDTH_MAX = 16'hFFFE;
  localparam logic [15:0] SPLIT_LEN_RST = 16'h0002;
  localparam logic [15:0] SPLIT_WIDTH_RST = 16'h0001;
  localparam logic [15:0] READ_DATA_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;       // Reference clock period.
  localparam int PULSE_PERIOD_NS = 40;     // Fixed pulse period while driving.
  localparam int PULSE_PERIOD_CYC = (PULSE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Drive sequencer states, Gray coded along idle, run, hold.
  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_RUN = 2'b01,
    DRV_HOLD = 2'b11
  } ardc_drv_e;

endpackage : ardc_pkg

// [test/ardc_host_model.sv]
// Host model: writes command words and parameters to the block.
// Assumes the bench calls send from a single thread.
`timescale 1ns/1ps
module ardc_host_model (
  // Clock.
  input wire logic ref_clk,
  // Command write port.
  output logic command_wr,
  output logic [15:0] command_register,
  output logic [31:0] command_param
);
  // Idle bus at time zero.
  initial begin
    command_wr = 1'b0;
    command_register = 16'h0000;
    command_param = 32'h00000000;
  end
  // One-cycle strobe, then the parameter is scrambled so stale data is never read.
  task automatic send(input logic [7:0] code, input logic [3:0] axes,
      input logic [31:0] prm);
    @(negedge ref_clk);
    command_wr = 1'b1;
    command_register = {4'h0, axes, code};
    command_param = prm;
    @(negedge ref_clk);
    command_wr = 1'b0;
    command_param = ~prm;
    @(negedge ref_clk);
  endtask : send
endmodule : ardc_host_model

// [test/tb_axis_readback_and_drive_cmds.sv]
// Testbench: readbacks, synchronous loads and relative drives.
// Assumes the host model issues every command word.
`timescale 1ns/1ps
module tb_axis_readback_and_drive_cmds;
  import ardc_pkg::*;
  logic ref_clk, rst, command_wr, i2c_mode_pin;
  logic [15:0] command_register, host_data_bus_pins;
  logic [15:0] read_data_low, read_data_high, main_status_register;
  logic [31:0] command_param, multi_purpose_reg;
  logic [AXES-1:0] sync_load_pulse_count, sync_load_split;
  logic [AXES-1:0] servo_in_position_input, inpos_enable;
  logic [AXES-1:0] plus_pulse_output, minus_pulse_output;
  logic [7:0] general_input_pins;
  logic [AXES*32-1:0] logical_position;
  int fail_count = 0;
  int total_checks = 0;
  int np, nm;
  ardc_host_model host (.ref_clk, .command_wr, .command_register, .command_param);
  ardc_cmd_top dut (.ref_clk, .rst, .command_wr, .command_register, .command_param,
    .sync_load_pulse_count, .sync_load_split, .multi_purpose_reg, .i2c_mode_pin,
    .host_data_bus_pins, .general_input_pins, .servo_in_position_input, .inpos_enable,
    .read_data_low, .read_data_high, .main_status_register, .plus_pulse_output,
    .minus_pulse_output, .logical_position);
  // Free-running 100 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Compare and count; case inequality so unknowns never match.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Verdict and end of run.
  task automatic final_report();
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // Count pulses of one axis while it is busy, bounded by lim cycles.
  // The first pulse already stands when the drive command returns, so each
  // cycle is sampled before waiting. Running out counts as a failure if the
  // axis was expected to go idle.
  task automatic watch(input int ax, input int lim, input logic must_end);
    np = 0;
    nm = 0;
    for (int i = 0; i < lim && main_status_register[ax] === 1'b1; i++) begin
      np += plus_pulse_output[ax];
      nm += minus_pulse_output[ax];
      @(negedge ref_clk);
    end
    if (must_end && main_status_register[ax] !== 1'b0) begin
      fail_count++;
      final_report();
    end
  endtask : watch
  // Pulse a synchronous load for one cycle.
  task automatic sload(input logic split, input logic [3:0] ax, input logic [31:0] v);
    multi_purpose_reg = v;
    if (split) sync_load_split = ax;
    else sync_load_pulse_count = ax;
    @(negedge ref_clk);
    sync_load_split = 4'h0;
    sync_load_pulse_count = 4'h0;
  endtask : sload
  // Main sequence.
  initial begin
    rst = 1'b1;
    multi_purpose_reg = 32'h0;
    sync_load_pulse_count = 4'h0;
    sync_load_split = 4'h0;
    servo_in_position_input = 4'h0;
    inpos_enable = 4'h4;
    i2c_mode_pin = 1'b0;
    host_data_bus_pins = 16'h3C5A;
    general_input_pins = 8'hA5;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("reset read", {read_data_high, read_data_low}, 32'h0);
    check("reset status", {16'h0, main_status_register}, 32'h0);
    host.send(CMD_SET_PULSE_COUNT, 4'h2, 32'h12345678);
    host.send(CMD_READ_PULSE_COUNT, 4'h2, 32'h0);
    check("count", {read_data_high, read_data_low}, 32'h12345678);
    sload(1'b0, 4'h2, 32'hFFFFFFFD);
    host.send(CMD_READ_PULSE_COUNT, 4'h2, 32'h0);
    check("loaded count", {read_data_high, read_data_low}, 32'hFFFFFFFD);
    host.send(CMD_SET_SPLIT, 4'h1, 32'h00050009);
    host.send(CMD_READ_SPLIT, 4'h1, 32'h0);
    check("split", {read_data_high, read_data_low}, 32'h00050009);
    sload(1'b1, 4'h1, 32'hFFFEFFFF);
    host.send(CMD_READ_SPLIT, 4'h1, 32'h0);
    check("loaded split", {read_data_high, read_data_low}, 32'hFFFEFFFF);
    host.send(CMD_READ_INPUTS, 4'h0, 32'h0);
    check("inputs", {read_data_high, read_data_low}, 32'h00A50000);
    i2c_mode_pin = 1'b1;
    general_input_pins = 8'h5A;
    repeat (3) @(negedge ref_clk);
    host.send(CMD_READ_INPUTS, 4'h0, 32'h0);
    check("inputs i2c", {read_data_high, read_data_low}, 32'h005A3C5A);
    host.send(8'hFF, 4'h1, 32'h0);
    check("unknown code", {read_data_high, read_data_low}, 32'h005A3C5A);
    // Fixed-speed drive only, so the pulse count is the one parameter to set.
    host.send(CMD_SET_PULSE_COUNT, 4'h1, 32'd2);
    host.send(CMD_DRIVE_RELATIVE, 4'h1, 32'h0);
    check("busy0", main_status_register[0], 1'b1);
    watch(0, 40, 1'b1);
    check("plus0", np, 2);
    check("minus0", nm, 0);
    check("pos0", logical_position[31:0], 32'd2);
    check("idle0", main_status_register[0], 1'b0);
    host.send(CMD_SET_PULSE_COUNT, 4'h4, 32'hFFFFFFFD);
    host.send(CMD_DRIVE_RELATIVE, 4'h4, 32'h0);
    watch(2, 40, 1'b0);
    check("minus2", nm, 3);
    check("plus2", np, 0);
    check("pos2", logical_position[95:64], 32'hFFFFFFFD);
    check("hold2", main_status_register[2], 1'b1);
    servo_in_position_input = 4'h4;
    watch(2, 10, 1'b1);
    check("free2", main_status_register[2], 1'b0);
    final_report();
  end
endmodule : tb_axis_readback_and_drive_cmds
